// ### rtl/readout_cfg.svh
// timing counts and field widths shared by both ends of the readout link
`ifndef READOUT_CFG_SVH
`define READOUT_CFG_SVH

`define CLK_PERIOD_NS        10
`define COL_ADDR_W           10
`define ROW_ADDR_W           10
`define DIV_W                1
`define DIV_RESET_PHASE      1'h0
`define RST_HOLD_NS          1000
`define RST_HOLD_CYC         ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SER_PERIOD_NS        1000
`define SER_HALF_CYC         ((`SER_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define SER_SETUP_NS         500
`define SER_SETUP_CYC        ((`SER_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SER_WORD_W           8
`define ROW_RESET_NS         2000
`define ROW_RESET_CYC        ((`ROW_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### rtl/readout_pkg.sv
// types shared by the sensor model and the timing controller
package readout_pkg;
	typedef logic [9:0] col_addr_t;
	typedef logic [9:0] row_addr_t;
	typedef logic [7:0] ser_word_t;
	typedef enum logic [2:0] {
		CTL_RESET,
		CTL_ADDR,
		CTL_SER_SETUP,
		CTL_SER_SHIFT,
		CTL_RUN
	} ctl_state_t;
endpackage : readout_pkg

// ### rtl/readout_link_if.sv
// pins between the external timing controller and the sensor readout logic
`timescale 1ns/10ps
interface readout_link_if;
	logic                    register_reset_n;
	logic                    col_clk;
	logic                    col_sync;
	logic                    blank;
	logic                    column_discharge_input;
	logic                    row_reset;
	logic                    row_select;
	readout_pkg::col_addr_t  col_addr;
	readout_pkg::row_addr_t  row_addr;
	logic                    ld_col;
	logic                    ld_row;
	logic                    ser_clk;
	logic                    ser_data;

	modport sensor (
		input register_reset_n, col_clk, col_sync, blank, column_discharge_input,
		input row_reset, row_select, col_addr, row_addr, ld_col, ld_row, ser_clk, ser_data
	);
	modport ctrl (
		output register_reset_n, col_clk, col_sync, blank, column_discharge_input,
		output row_reset, row_select, col_addr, row_addr, ld_col, ld_row, ser_clk, ser_data
	);
endinterface : readout_link_if

// ### rtl/sensor_readout.sv
// sensor end: column divider, column read pointer, row pointer, adc config shift
`timescale 1ns/10ps
`include "readout_cfg.svh"

module sensor_readout (
	input  wire logic                    i_mclk,
	input  wire logic                    i_rst,
	input  wire logic                    i_ce,
	readout_link_if.sensor               link,
	output logic [`COL_ADDR_W-1:0]       o_col_ptr,
	output logic [`ROW_ADDR_W-1:0]       o_row_ptr,
	output logic                         o_row_reset_act,
	output logic                         o_col_discharged,
	output logic [`SER_WORD_W-1:0]       o_adc_cfg,
	output logic                         o_adc_cfg_valid
);
	logic                    reg_rst;
	logic                    col_clk_q_r;
	logic                    ser_clk_q_r;
	logic                    col_rise;
	logic                    ser_rise;
	logic [`DIV_W-1:0]       div_r;
	logic                    div_tick;
	logic [1:0]              sync_cnt_r;
	logic [`SER_WORD_W-1:0]  ser_sh_r;
	logic [3:0]              ser_cnt_r;

	// the register reset pin acts without the clock, like the main reset
	assign reg_rst  = i_rst | ~link.register_reset_n; // RULE4
	assign col_rise = link.col_clk & ~col_clk_q_r;
	assign ser_rise = link.ser_clk & ~ser_clk_q_r;
	// divided clock ticks every second column clock rise
	assign div_tick = col_rise & (div_r == `DIV_RESET_PHASE); // RULE1

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_mclk or posedge reg_rst) begin
		if (reg_rst) begin
			col_clk_q_r <= 1'h0;
			ser_clk_q_r <= 1'h0;
		end else if (i_ce) begin
			col_clk_q_r <= link.col_clk;
			ser_clk_q_r <= link.ser_clk;
		end
	end

	always_ff @(posedge i_mclk or posedge reg_rst) begin
		if (reg_rst) begin
			div_r <= `DIV_RESET_PHASE;
		end else if (i_ce) begin
			if (link.blank) begin
				div_r <= `DIV_RESET_PHASE; // RULE9
			end else if (col_rise) begin
				div_r <= div_r + 1'h1; // RULE1
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// column pointer: load start, then step by two per completed sync pair;
	// a pair cut short by sync low or by blank is dropped, the pointer does not move for it
	always_ff @(posedge i_mclk or posedge reg_rst) begin
		if (reg_rst) begin
			o_col_ptr          <= '0;
			sync_cnt_r         <= 2'h0;
		end else if (i_ce) begin
			if (link.ld_col) begin
				o_col_ptr          <= link.col_addr; // RULE11
				sync_cnt_r         <= 2'h0;
			end else if (link.blank) begin
				// divider held at its initial phase ticks on every column clock rise; blank keeps the sync count clear
				sync_cnt_r <= 2'h0; // RULE9
			end else if (div_tick) begin
				if (link.col_sync) begin // RULE14
					if (sync_cnt_r == 2'h1) begin
						o_col_ptr  <= o_col_ptr + `COL_ADDR_W'(2); // RULE2
						sync_cnt_r <= 2'h0;
					end else begin
						sync_cnt_r <= sync_cnt_r + 2'h1;
					end
				end else begin
					sync_cnt_r <= 2'h0; // RULE3
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_mclk or posedge reg_rst) begin
		if (reg_rst) begin
			o_row_ptr       <= '0;
			o_row_reset_act <= 1'h0;
		end else if (i_ce) begin
			if (link.ld_row) begin
				o_row_ptr <= link.row_addr; // RULE11
			end
			o_row_reset_act <= link.row_reset;
		end
	end

	always_ff @(posedge i_mclk or posedge reg_rst) begin
		if (reg_rst) begin
			o_col_discharged <= 1'h0;
		end else if (i_ce) begin
			o_col_discharged <= link.column_discharge_input; // RULE10
		end
	end

	////////////////////////////////////////////////////////////////////////
	// adc config: msb first, one bit per serial clock rise
	always_ff @(posedge i_mclk or posedge reg_rst) begin
		if (reg_rst) begin
			ser_sh_r        <= '0;
			ser_cnt_r       <= 4'h0;
			o_adc_cfg       <= '0;
			o_adc_cfg_valid <= 1'h0;
		end else if (i_ce) begin
			o_adc_cfg_valid <= 1'h0;
			if (ser_rise) begin
				ser_sh_r <= {ser_sh_r[`SER_WORD_W-2:0], link.ser_data}; // RULE6
				if (ser_cnt_r == 4'(`SER_WORD_W - 1)) begin
					ser_cnt_r       <= 4'h0;
					o_adc_cfg       <= {ser_sh_r[`SER_WORD_W-2:0], link.ser_data};
					o_adc_cfg_valid <= 1'h1;
				end else begin
					ser_cnt_r <= ser_cnt_r + 4'h1;
				end
			end
		end
	end
endmodule : sensor_readout

// ### rtl/readout_ctrl.sv
// controller end: reset, address upload, adc config, row/column sequencing
`timescale 1ns/10ps
`include "readout_cfg.svh"

// How it works
// [RULE1] column sync judged on divided clock
// [RULE2] even sync pairs advance read pointer
// [RULE3] controller drops sync only after even pair
// [RULE4] register reset clears registers asynchronously
// [RULE5] reset held through power-up, then upload
// [RULE6] controller updates falling, sensor samples rising
// [RULE7] serial clock 1000 ns, 500 ns setup
// [RULE8] nondestructive: longer first, shorter fourth interval; code keeps blank high with equal row reset and select intervals
// [RULE9] blank clears column divider phase
// [RULE10] discharge input grounds column lines
// [RULE11] readout may start any column, row
// [RULE12] close pixels re-addressed by fresh sync
// [RULE13] double sampling rereads rows spaced
// [RULE14] sync changes with column clock only
module readout_ctrl (
	input  wire logic                    i_mclk,
	input  wire logic                    i_rst,
	input  wire logic                    i_ce,
	input  wire logic                    i_start,
	input  wire logic                    i_ndr,
	input  wire logic [`COL_ADDR_W-1:0]  i_col_start,
	input  wire logic [`ROW_ADDR_W-1:0]  i_row_start,
	input  wire logic [`SER_WORD_W-1:0]  i_adc_cfg,
	input  wire logic                    i_col_discharge,
	readout_link_if.ctrl                 link,
	output logic                         o_busy,
	output logic                         o_running
);
	readout_pkg::ctl_state_t  st_r;
	logic [15:0]              cnt_r;
	logic [3:0]               bit_r;
	logic                     sclk_r;
	logic [`SER_WORD_W-1:0]   sh_r;
	logic [1:0]               cdiv_r;
	logic                     ndr_r;
	logic [15:0]              row_cnt_r;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			st_r      <= readout_pkg::CTL_RESET;
			cnt_r     <= 16'h0;
			bit_r     <= 4'h0;
			sclk_r    <= 1'h0;
			sh_r      <= '0;
			ndr_r     <= 1'h0;
			o_busy    <= 1'h1;
			o_running <= 1'h0;
			link.register_reset_n <= 1'h0;
			link.ld_col   <= 1'h0;
			link.ld_row   <= 1'h0;
			link.col_addr <= '0;
			link.row_addr <= '0;
			link.ser_clk  <= 1'h0;
			link.ser_data <= 1'h0;
		end else if (i_ce) begin
			link.ld_col <= 1'h0;
			link.ld_row <= 1'h0;
			unique case (st_r)
				readout_pkg::CTL_RESET: begin
					// held low through ramp-up, at least the hold time
					if (cnt_r == 16'(`RST_HOLD_CYC - 1)) begin // RULE4 RULE5
						link.register_reset_n <= 1'h1;
						cnt_r <= 16'h0;
						st_r  <= readout_pkg::CTL_ADDR;
					end else begin
						cnt_r <= cnt_r + 16'h1;
					end
				end
				readout_pkg::CTL_ADDR: begin
					if (i_start) begin
						link.col_addr <= i_col_start; // RULE5
						link.row_addr <= i_row_start;
						link.ld_col   <= 1'h1;
						link.ld_row   <= 1'h1;
						link.ser_data <= i_adc_cfg[`SER_WORD_W-1];
						sh_r  <= {i_adc_cfg[`SER_WORD_W-2:0], 1'h0};
						ndr_r <= i_ndr;
						cnt_r <= 16'h0;
						bit_r <= 4'h0;
						st_r  <= readout_pkg::CTL_SER_SETUP;
					end
				end
				readout_pkg::CTL_SER_SETUP: begin
					// first bit stands the full setup time before first rise
					if (cnt_r == 16'(`SER_SETUP_CYC - 1)) begin // RULE7
						link.ser_clk <= 1'h1;
						cnt_r <= 16'h0;
						st_r  <= readout_pkg::CTL_SER_SHIFT;
					end else begin
						cnt_r <= cnt_r + 16'h1;
					end
				end
				readout_pkg::CTL_SER_SHIFT: begin
					if (cnt_r == 16'(`SER_HALF_CYC - 1)) begin // RULE7
						cnt_r <= 16'h0;
						link.ser_clk <= ~link.ser_clk;
						if (link.ser_clk) begin
							// falling edge: present next bit
							link.ser_data <= sh_r[`SER_WORD_W-1]; // RULE6
							sh_r  <= {sh_r[`SER_WORD_W-2:0], 1'h0};
							bit_r <= bit_r + 4'h1;
							if (bit_r == 4'(`SER_WORD_W - 1)) begin
								st_r      <= readout_pkg::CTL_RUN;
								o_busy    <= 1'h0;
								o_running <= 1'h1;
							end
						end
					end else begin
						cnt_r <= cnt_r + 16'h1;
					end
				end
				readout_pkg::CTL_RUN: begin
					cnt_r <= 16'h0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// column clock from mclk/4; sync is updated only while the column clock is low, one mclk
	// after its fall, and follows o_running, so it stays high for the whole run
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cdiv_r        <= 2'h0;
			link.col_clk  <= 1'h0;
			link.col_sync <= 1'h0;
			link.column_discharge_input <= 1'h0;
		end else if (i_ce) begin
			cdiv_r <= cdiv_r + 2'h1;
			link.column_discharge_input <= i_col_discharge; // RULE10
			if (cdiv_r == 2'h1) begin
				link.col_clk <= 1'h1;
			end else if (cdiv_r == 2'h3) begin
				link.col_clk <= 1'h0;
			end
			if (cdiv_r == 2'h0) begin
				link.col_sync <= o_running; // RULE3 RULE14 RULE12
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// row sequence: row reset, then select; blank spans both in ndr mode
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			row_cnt_r       <= 16'h0;
			link.row_reset  <= 1'h0;
			link.row_select <= 1'h0;
			link.blank      <= 1'h1;
		end else if (i_ce) begin
			if (!o_running) begin
				row_cnt_r       <= 16'h0;
				link.row_reset  <= 1'h0;
				link.row_select <= 1'h0;
				link.blank      <= 1'h1;
			end else begin
				row_cnt_r <= (row_cnt_r == 16'(`ROW_RESET_CYC * 2 - 1)) ? 16'h0 : row_cnt_r + 16'h1; // RULE13
				link.row_reset  <= (row_cnt_r < 16'(`ROW_RESET_CYC));
				link.row_select <= (row_cnt_r >= 16'(`ROW_RESET_CYC));
				// ndr keeps blank high; row reset and select intervals stay equal, as in destructive mode
				link.blank <= ndr_r ? 1'h1 : (row_cnt_r < 16'(`ROW_RESET_CYC)); // RULE8 RULE9
			end
		end
	end
endmodule : readout_ctrl

// ### testbench/readout_link_asserts.sv
// link-level checks between the timing controller and the sensor end
`timescale 1ns/10ps
`include "readout_cfg.svh"

module readout_link_asserts (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic register_reset_n,
	input wire logic col_clk,
	input wire logic col_sync,
	input wire logic ld_col,
	input wire logic ld_row,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic row_reset,
	input wire logic row_select
);
	logic [7:0] low_cnt_r;
	logic [7:0] hi_cnt_r;

	default clocking cb @(posedge i_mclk); endclocking
	// a frozen clock enable stretches every link phase, so checks pause with it
	default disable iff (i_rst || !i_ce);

	////////////////////////////////
	// saturating so a stuck reset cannot wrap back under the limit
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			low_cnt_r <= 8'h00;
		else if (!register_reset_n && low_cnt_r != 8'hff)
			low_cnt_r <= low_cnt_r + 8'h01;
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			hi_cnt_r <= 8'h00;
		else
			hi_cnt_r <= ser_clk ? hi_cnt_r + 8'h01 : 8'h00;
	end

	////////////////////////////////
	property p_rst_hold;
		$rose(register_reset_n) |-> low_cnt_r >= 8'h63;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("register reset released too early");
	property p_quiet_in_rst;
		!register_reset_n |-> !ld_col && !ser_clk;
	endproperty
	a_quiet_in_rst: assert property (p_quiet_in_rst) else $error("link activity during reset");
	property p_ld_pulse;
		ld_col |-> ld_row && register_reset_n ##1 !ld_col;
	endproperty
	a_ld_pulse: assert property (p_ld_pulse) else $error("address load pulse malformed");
	property p_first_setup;
		ld_col |-> ##1 (!ser_clk)[*8] ##[41:60] $rose(ser_clk);
	endproperty
	a_first_setup: assert property (p_first_setup) else $error("first serial bit setup wrong");
	property p_data_hold;
		ser_clk && $past(ser_clk) |-> $stable(ser_data);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("serial data moved while clock high");
	property p_ser_half;
		$fell(ser_clk) |-> hi_cnt_r == `SER_HALF_CYC;
	endproperty
	a_ser_half: assert property (p_ser_half) else $error("serial clock high phase wrong");
	property p_col_div;
		$rose(col_clk) |=> col_clk ##1 !col_clk;
	endproperty
	a_col_div: assert property (p_col_div) else $error("column clock shape wrong");
	property p_ld_after_rst;
		ld_col |-> low_cnt_r >= 8'h63;
	endproperty
	a_ld_after_rst: assert property (p_ld_after_rst) else $error("address upload before reset hold");
	property p_row_excl;
		!(row_reset && row_select);
	endproperty
	a_row_excl: assert property (p_row_excl) else $error("row reset and row select overlap");

	c_load: cover property (ld_col);
	c_ser: cover property ($rose(ser_clk));
	c_sync: cover property ($rose(col_sync));
endmodule : readout_link_asserts

// ### testbench/pixel_readout_sequencing_tb.sv
// both ends joined; controller driven from its user side, sensor outputs judged
`timescale 1ns/10ps
`include "readout_cfg.svh"

module pixel_readout_sequencing_tb;
	logic       i_mclk = 1'b0;
	logic       i_rst, i_ce, i_start, i_ndr, i_col_discharge;
	logic [9:0] i_col_start, i_row_start, o_col_ptr, o_row_ptr;
	logic [7:0] i_adc_cfg, o_adc_cfg;
	logic       o_row_reset_act, o_col_discharged, o_adc_cfg_valid, o_busy, o_running;
	int         fail_count = 0;
	int         checks_done = 0;
	int         cyc = 0;

	readout_link_if readout_link_if_i ();
	sensor_readout sensor_readout_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .link(readout_link_if_i),
		.o_col_ptr(o_col_ptr), .o_row_ptr(o_row_ptr), .o_row_reset_act(o_row_reset_act),
		.o_col_discharged(o_col_discharged), .o_adc_cfg(o_adc_cfg), .o_adc_cfg_valid(o_adc_cfg_valid));
	readout_ctrl readout_ctrl_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_start(i_start), .i_ndr(i_ndr),
		.i_col_start(i_col_start), .i_row_start(i_row_start), .i_adc_cfg(i_adc_cfg),
		.i_col_discharge(i_col_discharge), .link(readout_link_if_i), .o_busy(o_busy), .o_running(o_running));
	readout_link_asserts readout_link_asserts_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
		.register_reset_n(readout_link_if_i.register_reset_n), .col_clk(readout_link_if_i.col_clk),
		.col_sync(readout_link_if_i.col_sync), .ld_col(readout_link_if_i.ld_col), .ld_row(readout_link_if_i.ld_row),
		.ser_clk(readout_link_if_i.ser_clk), .ser_data(readout_link_if_i.ser_data),
		.row_reset(readout_link_if_i.row_reset), .row_select(readout_link_if_i.row_select));

	always #5 i_mclk = ~i_mclk;

	// whole run needs about 3000 cycles
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 10000) begin
			fail_count++;
			print_verdict();
		end
	end

	////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : step

	task automatic do_reset();
		i_rst = 1'b1;
		step(2);
		chk("col_ptr in reset", 16'h0, 16'(o_col_ptr));
		i_rst = 1'b0;
	endtask : do_reset

	task automatic t_reset_hold();
		int n;
		n = 0;
		while (readout_link_if_i.register_reset_n !== 1'b1 && n < 300) begin
			step(1);
			n++;
		end
		chk("reset low cycles", 16'h1, 16'(n >= `RST_HOLD_CYC - 1));
		chk("busy after reset", 16'h1, 16'(o_busy));
	endtask : t_reset_hold

	task automatic t_config(input logic nondestructive_read, input logic [9:0] col, input logic [9:0] row, input logic [7:0] cfg);
		int n;
		n = 0;
		i_ndr = nondestructive_read;
		i_col_start = col;
		i_row_start = row;
		i_adc_cfg = cfg;
		i_start = 1'b1;
		while (readout_link_if_i.ld_col !== 1'b1 && n < 20) begin
			step(1);
			n++;
		end
		i_start = 1'b0;
		step(1);
		chk("row_ptr loaded", 16'(row), 16'(o_row_ptr));
		chk("col_ptr loaded", 16'(col), 16'(o_col_ptr));
		n = 0;
		while (o_adc_cfg_valid !== 1'b1 && n < 1000) begin
			step(1);
			n++;
		end
		chk("adc valid", 16'h1, 16'(o_adc_cfg_valid));
		chk("adc word", 16'(cfg), 16'(o_adc_cfg));
		// run starts at the eighth serial fall, half a serial period after the last rise
		step(`SER_HALF_CYC);
		chk("busy after config", 16'h0, 16'(o_busy));
		chk("running after config", 16'h1, 16'(o_running));
	endtask : t_config

	task automatic t_advance();
		logic [9:0] p0;
		logic [9:0] d;
		int         n;
		n = 0;
		step(2);
		chk("row reset at run start", 16'h1, 16'(o_row_reset_act));
		// the pointer only moves while blank is low, during line selection
		while (readout_link_if_i.blank !== 1'b0 && n < 500) begin
			step(1);
			n++;
		end
		p0 = o_col_ptr;
		// ten pairs, ending just as the next pair's last column rise is pending
		step(168);
		d = o_col_ptr - p0;
		chk("pointer advance", 16'h14, 16'(d));
		chk("row reset in selection", 16'h0, 16'(o_row_reset_act));
		i_ce = 1'b0;
		p0 = o_col_ptr;
		step(64);
		chk("pointer frozen", 16'(p0), 16'(o_col_ptr));
		i_ce = 1'b1;
	endtask : t_advance

	task automatic t_discharge();
		i_col_discharge = 1'b1;
		step(10);
		chk("discharge on", 16'h1, 16'(o_col_discharged));
		i_col_discharge = 1'b0;
		step(10);
		chk("discharge off", 16'h0, 16'(o_col_discharged));
	endtask : t_discharge

	task automatic t_ndr();
		logic [9:0] p0;
		// past the point where a destructive row sequence drops blank
		step(240);
		chk("blank in ndr", 16'h1, 16'(readout_link_if_i.blank));
		p0 = o_col_ptr;
		step(160);
		chk("pointer held by blank", 16'(p0), 16'(o_col_ptr));
	endtask : t_ndr

	////////////////////////////////
	initial begin
		i_rst = 1'b1;
		i_ce = 1'b1;
		i_start = 1'b0;
		i_ndr = 1'b0;
		i_col_discharge = 1'b0;
		i_col_start = 10'h000;
		i_row_start = 10'h000;
		i_adc_cfg = 8'h00;
		do_reset();
		t_reset_hold();
		t_config(1'b0, 10'h3fc, 10'h155, 8'ha5);
		t_advance();
		t_discharge();
		do_reset();
		t_reset_hold();
		t_config(1'b1, 10'h001, 10'h3ff, 8'h5a);
		t_ndr();
		print_verdict();
	end
endmodule : pixel_readout_sequencing_tb
